// ### design/qio_expander.sv
`timescale 1ns/1ns
`default_nettype none
module qio_expander (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic [qio_pkg::PORT_W-1:0] port_in,
  output logic [qio_pkg::PORT_W-1:0] port_out,
  output logic [qio_pkg::PORT_W-1:0] port_oe,
  output logic alert_n_out,
  output logic alert_n_oe
);
  import qio_pkg::*;

  localparam int VALID_WIN = ALERT_VALID_CYC;
  localparam int CLEAR_WIN = ALERT_CLEAR_CYC;

  logic [1:0] bus_s;
  logic [PORT_W-1:0] port_s;
  logic [2:0] addr_s;
  logic ack_s;
  logic scl_s;
  logic sda_s;

  qio_pup_if pup_if ();

  qio_sync #(.WIDTH(2), .INIT(BUS_IDLE)) u_bus_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .en(clk_en),
    .d({scl_in, sda_in}),
    .q_reg(bus_s)
  );

  qio_sync #(.WIDTH(PORT_W), .INIT(PORT_RESET)) u_port_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .en(clk_en),
    .d(port_in),
    .q_reg(port_s)
  );

  qio_sync #(.WIDTH(3), .INIT(ADDR_SEL_RESET)) u_addr_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .en(clk_en),
    .d({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
    .q_reg(addr_s)
  );

  qio_sync #(.WIDTH(1), .INIT(1'b0)) u_ack_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .en(clk_en),
    .d(pup_if.ack_tgl),
    .q_reg(ack_s)
  );

  qio_pullup_link u_link (
    .scl_clk(scl_clk),
    .resetn(resetn),
    .pup(pup_if.link)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  qio_state_t state_reg, state_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [BYTE_W-1:0] rx_reg, rx_next;
  logic [BYTE_W-1:0] tx_reg, tx_next;
  logic [BYTE_W-1:0] low_hold_reg, low_hold_next;
  logic [PORT_W-1:0] latch_reg, latch_next;
  logic [PORT_W-1:0] ref_reg, ref_next;
  logic [PORT_W-1:0] pup_mask_reg, pup_mask_next;
  logic [PORT_W-1:0] pup_out_reg, pup_out_next;
  logic rw_reg, rw_next;
  logic hi_reg, hi_next;
  logic nack_reg, nack_next;
  logic sda_oe_reg, sda_oe_next;
  logic alert_reg, alert_next;
  logic scl_d_reg, scl_d_next;
  logic sda_d_reg, sda_d_next;
  logic req_tgl_reg, req_tgl_next;
  logic pup_on_reg, pup_on_next;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_hit;
  logic snap;
  logic wr_apply;
  logic [BYTE_W-1:0] cur_byte;
  logic [BYTE_W-1:0] nxt_byte;
  logic [PORT_W-1:0] wr_word;

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // The all-zero general call can never match the fixed upper bits.
  assign addr_hit = (rx_reg[7:1] == {ADDR_FIXED, addr_s});
  assign cur_byte = hi_reg ? port_s[15:8] : port_s[7:0];
  assign nxt_byte = hi_reg ? port_s[7:0] : port_s[15:8];
  assign wr_word = {rx_reg, low_hold_reg};

  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    low_hold_next = low_hold_reg;
    latch_next = latch_reg;
    rw_next = rw_reg;
    hi_next = hi_reg;
    nack_next = nack_reg;
    sda_oe_next = sda_oe_reg;
    snap = 1'b0;
    wr_apply = 1'b0;
    scl_d_next = scl_s;
    sda_d_next = sda_s;
    // A Start or Stop mid-byte simply abandons the shift register.
    if (stop_c) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (start_c) begin
      state_next = ST_ADDR;
      bitcnt_next = 4'h0;
      hi_next = 1'b0;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_SKIP: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            rx_next = {rx_reg[6:0], sda_s};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == BIT_COUNT_BYTE) begin
            if (addr_hit) begin
              sda_oe_next = 1'b1;
              rw_next = rx_reg[0];
              state_next = ST_ADDR_ACK;
            end else begin
              state_next = ST_SKIP;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_rise && rw_reg) begin
            snap = 1'b1;
          end else if (scl_fall) begin
            bitcnt_next = 4'h0;
            if (rw_reg) begin
              tx_next = cur_byte;
              sda_oe_next = ~cur_byte[7];
              state_next = ST_RD;
            end else begin
              sda_oe_next = 1'b0;
              state_next = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            rx_next = {rx_reg[6:0], sda_s};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == BIT_COUNT_BYTE) begin
            sda_oe_next = 1'b1;
            state_next = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (scl_rise) begin
            if (!hi_reg) begin
              low_hold_next = rx_reg;
            end else begin
              latch_next = wr_word;
              wr_apply = 1'b1;
            end
          end else if (scl_fall) begin
            sda_oe_next = 1'b0;
            hi_next = ~hi_reg;
            bitcnt_next = 4'h0;
            state_next = ST_WR;
            snap = hi_reg;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bitcnt_reg == BIT_COUNT_LAST_TX) begin
              sda_oe_next = 1'b0;
              state_next = ST_RD_ACK;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              sda_oe_next = ~tx_reg[6];
              bitcnt_next = bitcnt_reg + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_next = sda_s;
            snap = 1'b1;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_next = ST_SKIP;
            end else begin
              hi_next = ~hi_reg;
              tx_next = nxt_byte;
              sda_oe_next = ~nxt_byte[7];
              bitcnt_next = 4'h0;
              state_next = ST_RD;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // The alert is a pure mismatch against the snapshot, so a revert clears it
  // and a change landing in the clearing cycle is folded into the snapshot.
  always_comb begin
    ref_next = snap ? port_s : ref_reg;
    alert_next = (port_s != ref_next);
  end

  // The strong pull-up also ends at a Stop, since the clock may then stand.
  always_comb begin
    req_tgl_next = req_tgl_reg;
    pup_on_next = pup_on_reg;
    pup_mask_next = pup_mask_reg;
    if (wr_apply && (wr_word != '0)) begin
      pup_mask_next = wr_word;
      req_tgl_next = ~req_tgl_reg;
      pup_on_next = 1'b1;
    end else if (pup_on_reg && (stop_c || scl_fall
                                || ack_s == req_tgl_reg)) begin
      // The first serial clock fall after the apply ends the pulse.
      pup_on_next = 1'b0;
    end
    pup_out_next = pup_on_next ? pup_mask_next : '0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      low_hold_reg <= 8'h00;
      latch_reg <= PORT_RESET;
      ref_reg <= PORT_RESET;
      pup_mask_reg <= 16'h0000;
      pup_out_reg <= 16'h0000;
      rw_reg <= 1'b0;
      hi_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      alert_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      req_tgl_reg <= 1'b0;
      pup_on_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      low_hold_reg <= low_hold_next;
      latch_reg <= latch_next;
      ref_reg <= ref_next;
      pup_mask_reg <= pup_mask_next;
      pup_out_reg <= pup_out_next;
      rw_reg <= rw_next;
      hi_reg <= hi_next;
      nack_reg <= nack_next;
      sda_oe_reg <= sda_oe_next;
      alert_reg <= alert_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      req_tgl_reg <= req_tgl_next;
      pup_on_reg <= pup_on_next;
    end
  end

  assign pup_if.req_tgl = req_tgl_reg;
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign port_out = pup_out_reg;
  assign port_oe = ~latch_reg | pup_out_reg;
  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_reg;

  AST_RESET_PORT_HIGH: assert property (@(posedge sys_clk)
    $rose(resetn) |-> (latch_reg == PORT_RESET) && (port_oe == '0))
    else $error("port not released high after reset");

  AST_ALERT_VALID: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (port_s != ref_reg && !snap) |-> ##[1:VALID_WIN] alert_reg)
    else $error("alert late after port change");

  AST_ALERT_PIN: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    alert_n_oe == alert_reg && !alert_n_out)
    else $error("alert pin not open-drain low");

  AST_ALERT_CLEAR: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (snap && $stable(port_s)) |=> ##[0:CLEAR_WIN] !alert_reg)
    else $error("alert not cleared after access");

  AST_READ_SNAP: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (state_reg == ST_RD_ACK && scl_rise && !stop_c && !start_c)
      |=> ref_reg == $past(port_s))
    else $error("read ack did not take snapshot");

  AST_WRITE_APPLY: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    wr_apply |=> latch_reg == {$past(rx_reg), $past(low_hold_reg)})
    else $error("written pair not applied to port");

  AST_PULLUP_ON: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (wr_apply && wr_word != '0) |=> pup_out_reg == $past(wr_word))
    else $error("strong pull-up missing after write");

  AST_ADDR_MATCH: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (state_reg == ST_ADDR_ACK) |-> rx_reg[7:1] == {ADDR_FIXED, addr_s}
      && rx_reg[7:1] != 7'h00)
    else $error("acknowledged a foreign address");

  AST_READ_DATA: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (state_reg == ST_RD) |-> sda_oe == ~tx_reg[7])
    else $error("read bit not driven from port byte");
endmodule : qio_expander
`default_nettype wire

// ### design/qio_pkg.sv
package qio_pkg;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [15:0] PORT_RESET = 16'hffff;
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
  localparam logic [3:0] BIT_COUNT_LAST_TX = 4'h7;
  localparam logic [1:0] BUS_IDLE = 2'h3;
  localparam logic [2:0] ADDR_SEL_RESET = 3'h0;
  localparam int unsigned SYS_CLK_KHZ = 10000;
  localparam int unsigned ALERT_VALID_DELAY_US = 4;
  localparam int unsigned ALERT_CLEAR_DELAY_US = 4;
  localparam int ALERT_VALID_CYC = ALERT_VALID_DELAY_US * SYS_CLK_KHZ / 1000;
  localparam int ALERT_CLEAR_CYC = ALERT_CLEAR_DELAY_US * SYS_CLK_KHZ / 1000;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_WR = 8'h08,
    ST_WR_ACK = 8'h10,
    ST_RD = 8'h20,
    ST_RD_ACK = 8'h40,
    ST_SKIP = 8'h80
  } qio_state_t;
endpackage : qio_pkg

// ### design/qio_pullup_link.sv
`timescale 1ns/1ns
`default_nettype none
module qio_pullup_link (
  input wire logic scl_clk,
  input wire logic resetn,
  qio_pup_if.link pup
);
  logic req_meta_reg;
  logic req_sync_reg;
  logic ack_reg;
  logic req_meta_next;
  logic req_sync_next;
  logic ack_next;

  // The request returns as the acknowledge on the third falling serial clock edge, after the first fall has already ended the pulse.
  always_comb begin
    req_meta_next = pup.req_tgl;
    req_sync_next = req_meta_reg;
    ack_next = req_sync_reg;
  end

  always_ff @(negedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_meta_next;
      req_sync_reg <= req_sync_next;
      ack_reg <= ack_next;
    end
  end

  assign pup.ack_tgl = ack_reg;
endmodule : qio_pullup_link
`default_nettype wire

// ### design/qio_pup_if.sv
`timescale 1ns/1ns
`default_nettype none
interface qio_pup_if;
  logic req_tgl;
  logic ack_tgl;
  modport sys (output req_tgl, input ack_tgl);
  modport link (input req_tgl, output ack_tgl);
endinterface : qio_pup_if
`default_nettype wire

// ### design/qio_sync.sv
`timescale 1ns/1ns
`default_nettype none
module qio_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q_reg
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    meta_next = en ? d : meta_reg;
    q_next = en ? meta_reg : q_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end
endmodule : qio_sync
`default_nettype wire

// ### verification/qio_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module qio_i2c_master (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt

  // Low phase is 1.4 us and high phase 1 us, a 2.4 us bit, so SCL runs just above 400 kHz.
  task automatic bit_io(input logic b, output logic s);
    sda_oe = ~b;
    wt(10);
    scl = 1'b1;
    wt(5);
    s = sda;
    wt(5);
    scl = 1'b0;
    wt(4);
  endtask : bit_io

  task automatic start();
    wt(8);
    sda_oe = 1'b1;
    wt(8);
    scl = 1'b0;
    wt(4);
  endtask : start

  task automatic stop();
    sda_oe = 1'b1;
    wt(10);
    scl = 1'b1;
    wt(8);
    sda_oe = 1'b0;
    wt(15);
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, s);
  endtask : rbyte
endmodule : qio_i2c_master
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import qio_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] asel = 3'h5;
  logic [15:0] ext_low = 16'h0000;
  logic scl;
  logic m_oe;
  logic dut_oe;
  logic sda_out;
  logic alert_n_out;
  logic alert_n_oe;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  logic [15:0] port_in;
  logic sda;
  logic ack;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [15:0] pup_last = 16'h0000;
  int num_errors = 0;
  int n_checks = 0;

  // Both buses carry pull-ups, so a released line reads high.
  assign sda = ~m_oe & (~dut_oe | sda_out);
  assign port_in = ~((port_oe & ~port_out)
    | (ext_low & ~(port_oe & port_out)));

  // The strong pull-up lasts only part of a bit, so its last pattern is kept.
  always @(negedge sys_clk) begin
    if (port_out != 16'h0000) begin
      pup_last <= port_out;
    end
  end

  initial forever #50 sys_clk = ~sys_clk;

  qio_i2c_master m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  qio_expander dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
    .scl_clk(scl), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(dut_oe), .addr_select_bit0(asel[0]),
    .addr_select_bit1(asel[1]), .addr_select_bit2(asel[2]),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_val(input logic [15:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk_bit

  task automatic wait_alert(input logic exp);
    for (int i = 0; i < 40 && alert_n_oe !== exp; i++) begin
      @(negedge sys_clk);
    end
    chk_bit(alert_n_oe, exp, "alert level");
    if (alert_n_oe !== exp) begin
      final_report();
    end
  endtask : wait_alert

  task automatic wr16(input logic [15:0] v);
    m.start();
    m.wbyte({ADDR_FIXED, asel, 1'b0}, ack);
    m.wbyte(v[7:0], ack);
    m.wbyte(v[15:8], ack);
    m.stop();
  endtask : wr16

  task automatic t_reset();
    chk_val(port_oe, 16'h0000, "weak pull-up only");
    chk_val(port_in, PORT_RESET, "lines high");
    chk_bit(dut_oe, 1'b0, "sda released");
    chk_bit(alert_n_oe, 1'b0, "alert idle");
  endtask : t_reset

  task automatic t_write();
    m.start();
    m.wbyte({ADDR_FIXED, asel, 1'b0}, ack);
    chk_bit(ack, 1'b1, "address ack");
    m.wbyte(8'h5a, ack);
    chk_bit(ack, 1'b1, "low byte ack");
    chk_val(port_in, 16'hffff, "low byte held");
    m.wbyte(8'h0f, ack);
    chk_bit(ack, 1'b1, "high byte ack");
    chk_val(port_in, 16'h0f5a, "pair applied");
    chk_val(pup_last, 16'h0f5a, "strong pull-up on");
    chk_val(port_out, 16'h0000, "pull-up ends at clock fall");
    m.wbyte(8'h34, ack);
    m.wbyte(8'h12, ack);
    chk_val(port_in, 16'h1234, "second pair");
    chk_val(pup_last, 16'h1234, "pull-up second pair");
    m.wbyte(8'h00, ack);
    m.stop();
    chk_val(port_in, 16'h1234, "odd byte dropped");
    chk_val(port_oe, 16'hedcb, "strong pull-up off");
    chk_val(port_out, 16'h0000, "pull-up released");
  endtask : t_write

  task automatic t_refuse();
    m.start();
    m.wbyte({ADDR_FIXED, asel ^ 3'h1, 1'b0}, ack);
    chk_bit(ack, 1'b0, "other address");
    m.wbyte(8'h00, ack);
    m.stop();
    m.start();
    m.wbyte(8'h00, ack);
    chk_bit(ack, 1'b0, "general call");
    m.wbyte(8'h00, ack);
    m.stop();
    chk_val(port_in, 16'h1234, "port kept");
  endtask : t_refuse

  task automatic t_alert();
    wr16(16'hffff);
    ext_low = 16'h0008;
    wait_alert(1'b1);
    chk_bit(alert_n_out, 1'b0, "open drain low");
    ext_low = 16'h0000;
    wait_alert(1'b0);
    ext_low = 16'h0008;
    wait_alert(1'b1);
    m.start();
    m.wbyte({ADDR_FIXED, asel ^ 3'h2, 1'b0}, ack);
    m.wbyte(8'h00, ack);
    m.stop();
    chk_bit(alert_n_oe, 1'b1, "foreign traffic");
    m.start();
    m.wbyte({ADDR_FIXED, asel, 1'b1}, ack);
    chk_bit(ack, 1'b1, "read address ack");
    m.rbyte(1'b1, d0);
    m.rbyte(1'b0, d1);
    m.stop();
    chk_val({d1, d0}, 16'hfff7, "read levels");
    chk_bit(alert_n_oe, 1'b0, "read clears");
    ext_low = 16'h0000;
    wait_alert(1'b1);
    wr16(16'hffff);
    chk_bit(alert_n_oe, 1'b0, "write clears");
  endtask : t_alert

  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_write();
    t_refuse();
    t_alert();
    final_report();
  end

  // A hung handshake would otherwise run forever.
  initial begin
    #5000000;
    num_errors++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
